/* bench/tb_spread_modem_packet_config_regs.sv */
`timescale 1ns/10ps
module tb_spread_modem_packet_config_regs;
  import spm_pkg::*;
  // ==========
  // Signals
  logic ref_clk = 0;
  logic nrst = 0;
  logic ser_clk = 0, ser_select_n = 1, ser_data_in = 0, ser_data_out;
  logic packet_active = 0, symbol_tick = 0, first_header_symbol = 0, header_valid = 0;
  logic [7:0] header_payload_length = 8'h00;
  logic implicit_header_select = 0, rx_byte_written = 0;
  logic [7:0] rx_byte_addr = 8'h00;
  logic [2:0] manual_gain_setting = 3'h0, agc_gain = 3'h0, lna_gain;
  logic [15:0] preamble_symbol_count;
  logic [18:0] preamble_quarter_symbols;
  logic header_crc_error, hop_request, long_symbol_optimise;
  int fails = 0, tests_run = 0;
  int ph = 0, pl = 8, lim = 255, hop = 0, ptr = 0, cfg = 0;
  logic [7:0] rnd = 8'h37;
  logic [6:0] addrs [10] = '{7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27, 7'h3F, 7'h1F};

  spm_packet_config i_dut (.ref_clk(ref_clk), .nrst(nrst), .ser_clk(ser_clk), .ser_select_n(ser_select_n),
    .ser_data_in(ser_data_in), .ser_data_out(ser_data_out), .packet_active(packet_active),
    .symbol_tick(symbol_tick), .first_header_symbol(first_header_symbol), .header_valid(header_valid),
    .header_payload_length(header_payload_length), .implicit_header_select(implicit_header_select),
    .rx_byte_written(rx_byte_written), .rx_byte_addr(rx_byte_addr), .manual_gain_setting(manual_gain_setting),
    .agc_gain(agc_gain), .preamble_symbol_count(preamble_symbol_count),
    .preamble_quarter_symbols(preamble_quarter_symbols), .header_crc_error(header_crc_error),
    .hop_request(hop_request), .long_symbol_optimise(long_symbol_optimise), .lna_gain(lna_gain));

  always #12.5 ref_clk = ~ref_clk;

  // ==========
  // Helpers and reference model
  function logic [7:0] next_rnd(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function int mrd(input logic [6:0] a);
    case (a)
      7'h20: return ph;
      7'h21: return pl;
      7'h23: return lim;
      7'h24: return hop;
      7'h25: return ptr;
      7'h26: return cfg;
      default: return 0;
    endcase
  endfunction

  // Serial pins held 8 ref_clk cycles per level, well over the synchroniser need
  task xfer(input logic wr, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {wr, a, d};
    q = 8'h00;
    ser_select_n = 0;
    cyc(8);
    for (int i = 15; i >= 0; i--)
    begin
      ser_data_in = f[i];
      cyc(8);
      if (i < 8) q = {q[6:0], ser_data_out};
      ser_clk = 1;
      cyc(8);
      ser_clk = 0;
    end
    cyc(8);
    ser_select_n = 1;
    cyc(8);
  endtask

  task reg_wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
    case (a)
      7'h20: ph = d;
      7'h21: pl = d;
      7'h23: lim = d;
      7'h24: hop = d;
      7'h26: cfg = d & 8'h0C;
      default: ;
    endcase
  endtask

  task reg_rd(input logic [6:0] a);
    logic [7:0] q;
    rnd = next_rnd(rnd);
    xfer(1'b0, a, rnd, q);
    chk("register read", mrd(a), q);
  endtask

  task chk_outs;
    chk("preamble_symbol_count", ph * 256 + pl, preamble_symbol_count);
    chk("preamble_quarter_symbols", (ph * 256 + pl) * 4 + 17, preamble_quarter_symbols);
    chk("long_symbol_optimise", cfg[3], long_symbol_optimise);
  endtask

  task hop_run(input int iv);
    reg_wr(SPM_ADDR_HOP_INTERVAL, iv[7:0]);
    packet_active = 1;
    cyc(3);
    symbol_tick = 1;
    cyc(1);
    symbol_tick = 0;
    chk("hop_request early", 0, hop_request);
    cyc(2);
    first_header_symbol = 1;
    cyc(1);
    first_header_symbol = 0;
    chk("hop_request first", iv != 0, hop_request);
    for (int k = 1; k <= 6; k++)
    begin
      cyc(2);
      symbol_tick = 1;
      cyc(1);
      symbol_tick = 0;
      chk("hop_request tick", iv != 0 && k % iv == 0, hop_request);
    end
    packet_active = 0;
    cyc(3);
  endtask

  task end_of_test;
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========
  // Main sequence
  initial
  begin
    cyc(12);
    nrst = 1;
    cyc(6);
    chk_outs();
    foreach (addrs[i]) reg_rd(addrs[i]);
    // Every address written, reserved and read-only ones included
    foreach (addrs[i])
    begin
      rnd = next_rnd(rnd);
      // The LFSR never yields zero, so the payload length register never gets zero
      reg_wr(addrs[i], rnd);
      reg_rd(addrs[i]);
      chk_outs();
    end
    // Largest count: the 4.25 symbol extension must not wrap
    reg_wr(SPM_ADDR_PREAMBLE_HIGH, 8'hFF);
    reg_wr(SPM_ADDR_PREAMBLE_LOW, 8'hFF);
    chk_outs();
    // Header length ceiling around its boundary, both header modes
    reg_wr(SPM_ADDR_PAYLOAD_LIMIT, 8'h0F);
    for (int m = 0; m < 2; m++)
      foreach (addrs[i])
      begin
        implicit_header_select = m[0];
        header_payload_length = {1'b0, addrs[i]} - 8'h12;
        header_valid = 1;
        cyc(1);
        header_valid = 0;
        chk("header_crc_error", m == 0 && header_payload_length > lim, header_crc_error);
        cyc(1);
        chk("header_crc_error end", 0, header_crc_error);
      end
    implicit_header_select = 0;
    header_payload_length = 8'h10;
    header_valid = 1;
    cyc(1);
    header_payload_length = 8'h05;
    chk("header_crc_error b2b", 1, header_crc_error);
    cyc(1);
    header_valid = 0;
    chk("header_crc_error b2b", 0, header_crc_error);
    hop_run(0);
    hop_run(1);
    hop_run(3);
    repeat (3)
    begin
      rnd = next_rnd(rnd);
      rx_byte_addr = rnd;
      rx_byte_written = 1;
      cyc(1);
      rx_byte_written = 0;
      ptr = rnd;
      reg_rd(SPM_ADDR_RX_POINTER);
    end
    for (int b = 0; b < 2; b++)
    begin
      reg_wr(SPM_ADDR_CONFIG_THIRD, b ? 8'hF7 : 8'hFB);
      repeat (4)
      begin
        rnd = next_rnd(rnd);
        manual_gain_setting = rnd[2:0];
        agc_gain = rnd[5:3];
        cyc(2);
        chk("lna_gain", b ? rnd[5:3] : rnd[2:0], lna_gain);
      end
      reg_rd(SPM_ADDR_CONFIG_THIRD);
      chk_outs();
    end
    end_of_test();
  end

  initial
  begin
    // About 43 frames of 280 cycles each are expected; the limit leaves ample margin
    repeat (40000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end
endmodule

/* src/spm_packet_config.sv */
`timescale 1ns/10ps
module spm_packet_config
  import spm_pkg::*;
#(
  parameter int GAIN_W = 3
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Host serial port
  input wire logic ser_clk,
  input wire logic ser_select_n,
  input wire logic ser_data_in,
  output logic ser_data_out,
  // Modem status
  input wire logic packet_active,
  input wire logic symbol_tick,
  input wire logic first_header_symbol,
  input wire logic header_valid,
  input wire logic [7:0] header_payload_length,
  input wire logic implicit_header_select,
  input wire logic rx_byte_written,
  input wire logic [7:0] rx_byte_addr,
  // Gain sources
  input wire logic [GAIN_W-1:0] manual_gain_setting,
  input wire logic [GAIN_W-1:0] agc_gain,
  // Modem controls
  output logic [15:0] preamble_symbol_count,
  output logic [18:0] preamble_quarter_symbols,
  output logic header_crc_error,
  output logic hop_request,
  output logic long_symbol_optimise,
  output logic [GAIN_W-1:0] lna_gain
);
  // ==========================================
  // Register access
  logic [6:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wr_data;
  logic [7:0] reg_rd_data;

  spm_serial_port u_port (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ser_clk(ser_clk),
    .ser_select_n(ser_select_n),
    .ser_data_in(ser_data_in),
    .ser_data_out(ser_data_out),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data)
  );

  logic [7:0] preamble_count_high, preamble_count_low, payload_size_limit;
  logic [7:0] hop_interval, rx_buffer_write_pointer, modem_config_third;
  logic [7:0] next_high, next_low, next_limit, next_hop, next_ptr, next_cfg3;

  always_comb
  begin
    next_high = preamble_count_high;
    next_low = preamble_count_low;
    next_limit = payload_size_limit;
    next_hop = hop_interval;
    next_cfg3 = modem_config_third;
    if (rx_byte_written)
      next_ptr = rx_byte_addr;
    else
      next_ptr = rx_buffer_write_pointer;
    if (reg_wr)
    begin
      case (reg_addr)
        SPM_ADDR_PREAMBLE_HIGH: next_high = reg_wr_data;
        SPM_ADDR_PREAMBLE_LOW: next_low = reg_wr_data;
        SPM_ADDR_PAYLOAD_LIMIT: next_limit = reg_wr_data;
        SPM_ADDR_HOP_INTERVAL: next_hop = reg_wr_data;
        SPM_ADDR_CONFIG_THIRD: next_cfg3 = reg_wr_data & SPM_CONFIG_THIRD_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      preamble_count_high <= SPM_RST_PREAMBLE_HIGH;
      preamble_count_low <= SPM_RST_PREAMBLE_LOW;
      payload_size_limit <= SPM_RST_PAYLOAD_LIMIT;
      hop_interval <= SPM_RST_HOP_INTERVAL;
      rx_buffer_write_pointer <= SPM_RST_RX_POINTER;
      modem_config_third <= SPM_RST_CONFIG_THIRD;
    end
    else
    begin
      preamble_count_high <= next_high;
      preamble_count_low <= next_low;
      payload_size_limit <= next_limit;
      hop_interval <= next_hop;
      rx_buffer_write_pointer <= next_ptr;
      modem_config_third <= next_cfg3;
    end
  end

  always_comb
  begin
    case (reg_addr)
      SPM_ADDR_PREAMBLE_HIGH: reg_rd_data = preamble_count_high;
      SPM_ADDR_PREAMBLE_LOW: reg_rd_data = preamble_count_low;
      SPM_ADDR_PAYLOAD_LIMIT: reg_rd_data = payload_size_limit;
      SPM_ADDR_HOP_INTERVAL: reg_rd_data = hop_interval;
      SPM_ADDR_RX_POINTER: reg_rd_data = rx_buffer_write_pointer;
      SPM_ADDR_CONFIG_THIRD: reg_rd_data = modem_config_third & SPM_CONFIG_THIRD_MASK;
      default: reg_rd_data = 8'h00;
    endcase
  end

  // ==========================================
  // Preamble and configuration outputs
  assign preamble_symbol_count = {preamble_count_high, preamble_count_low};
  // Quarter symbols keep the 0.25 fraction exact without a fixed-point divide
  // One spare bit: a full count of 0xFFFF plus 4.25 symbols would wrap in 18 bits
  assign preamble_quarter_symbols = {1'b0, preamble_symbol_count, 2'b00}
                                    + {1'b0, SPM_PREAMBLE_EXTRA_QUARTERS};
  // Software owns this bit; the block only forwards it
  assign long_symbol_optimise = modem_config_third[SPM_BIT_LONG_SYMBOL];

  // ==========================================
  // Header check and gain source
  logic next_crc_error;
  logic [GAIN_W-1:0] next_gain;

  always_comb
  begin
    // Implicit headers carry no length field, so nothing to check
    next_crc_error = header_valid && !implicit_header_select
                     && (header_payload_length > payload_size_limit);
    if (modem_config_third[SPM_BIT_AUTO_GAIN])
      next_gain = agc_gain;
    else
      next_gain = manual_gain_setting;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      header_crc_error <= 1'b0;
      lna_gain <= '0;
    end
    else
    begin
      header_crc_error <= next_crc_error;
      lna_gain <= next_gain;
    end
  end

  // ==========================================
  // Frequency hop timing
  spm_hop_state_t hop_state, next_hop_state;
  logic [7:0] sym_cnt, next_sym_cnt;
  logic next_hop_request;

  always_comb
  begin
    next_hop_state = hop_state;
    next_sym_cnt = sym_cnt;
    next_hop_request = 1'b0;
    case (hop_state)
      HOP_OFF:
        if (packet_active && hop_interval != 8'h00)
          next_hop_state = HOP_WAIT_HEADER;
      HOP_WAIT_HEADER:
        if (!packet_active || hop_interval == 8'h00)
          next_hop_state = HOP_OFF;
        else if (first_header_symbol)
        begin
          next_hop_request = 1'b1;
          next_sym_cnt = 8'h00;
          next_hop_state = HOP_RUN;
        end
      HOP_RUN:
        if (!packet_active || hop_interval == 8'h00)
          next_hop_state = HOP_OFF;
        else if (symbol_tick)
        begin
          if (sym_cnt + 8'h01 >= hop_interval)
          begin
            next_hop_request = 1'b1;
            next_sym_cnt = 8'h00;
          end
          else
            next_sym_cnt = sym_cnt + 8'h01;
        end
      default: next_hop_state = HOP_OFF;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      hop_state <= HOP_OFF;
      sym_cnt <= 8'h00;
      hop_request <= 1'b0;
    end
    else
    begin
      hop_state <= next_hop_state;
      sym_cnt <= next_sym_cnt;
      hop_request <= next_hop_request;
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence low_written;
    reg_wr && reg_addr == SPM_ADDR_PREAMBLE_LOW;
  endsequence
  sequence hop_armed;
    hop_state == HOP_WAIT_HEADER && packet_active && hop_interval != 8'h00;
  endsequence

  preamble_low_a: assert property (low_written |=> preamble_symbol_count[7:0] == $past(reg_wr_data))
    else $error("preamble low byte not stored");
  preamble_total_a: assert property (preamble_quarter_symbols[1:0] == 2'b01
    && preamble_quarter_symbols[18:2] == ({1'b0, preamble_symbol_count} + 17'h00004))
    else $error("preamble total not count plus 4.25");
  length_reject_a: assert property (header_valid && !implicit_header_select
    && header_payload_length > payload_size_limit |=> header_crc_error)
    else $error("oversize header length not flagged");
  length_accept_a: assert property (header_valid && header_payload_length <= payload_size_limit
    |=> !header_crc_error)
    else $error("legal header length flagged");
  implicit_check_a: assert property (implicit_header_select |=> !header_crc_error)
    else $error("implicit header checked for length");
  hop_disabled_a: assert property (hop_interval == 8'h00 && $past(hop_interval) == 8'h00 |-> !hop_request)
    else $error("hop while hopping disabled");
  first_hop_a: assert property (hop_armed ##0 first_header_symbol |=> hop_request ##1 !hop_request)
    else $error("first hop not after first header symbol");
  rx_pointer_a: assert property (rx_byte_written |=> rx_buffer_write_pointer == $past(rx_byte_addr))
    else $error("receive pointer not updated");
  gain_source_a: assert property (##1 lna_gain == ($past(modem_config_third[SPM_BIT_AUTO_GAIN])
    ? $past(agc_gain) : $past(manual_gain_setting)))
    else $error("gain from wrong source");
  config_reserved_a: assert property (reg_addr == SPM_ADDR_CONFIG_THIRD |-> (reg_rd_data & 8'hF3) == 8'h00)
    else $error("reserved config bits read nonzero");
endmodule

/* src/spm_pkg.sv */
package spm_pkg;
  // Register map, 7-bit serial address
  localparam logic [6:0] SPM_ADDR_PREAMBLE_HIGH = 7'h20;
  localparam logic [6:0] SPM_ADDR_PREAMBLE_LOW = 7'h21;
  localparam logic [6:0] SPM_ADDR_PAYLOAD_LIMIT = 7'h23;
  localparam logic [6:0] SPM_ADDR_HOP_INTERVAL = 7'h24;
  localparam logic [6:0] SPM_ADDR_RX_POINTER = 7'h25;
  localparam logic [6:0] SPM_ADDR_CONFIG_THIRD = 7'h26;
  // Reset values
  localparam logic [7:0] SPM_RST_PREAMBLE_HIGH = 8'h00;
  localparam logic [7:0] SPM_RST_PREAMBLE_LOW = 8'h08;
  localparam logic [7:0] SPM_RST_PAYLOAD_LIMIT = 8'hFF;
  localparam logic [7:0] SPM_RST_HOP_INTERVAL = 8'h00;
  localparam logic [7:0] SPM_RST_RX_POINTER = 8'h00;
  localparam logic [7:0] SPM_RST_CONFIG_THIRD = 8'h00;
  // Third modem configuration byte fields
  localparam int SPM_BIT_LONG_SYMBOL = 3;
  localparam int SPM_BIT_AUTO_GAIN = 2;
  localparam logic [7:0] SPM_CONFIG_THIRD_MASK = 8'h0C;
  // Fixed preamble extension, 4.25 symbols held in quarter symbols
  localparam logic [17:0] SPM_PREAMBLE_EXTRA_QUARTERS = 18'h00011;
  // Serial frame layout
  localparam logic [4:0] SPM_SER_HEADER_BITS = 5'h08;
  localparam logic [4:0] SPM_SER_FRAME_BITS = 5'h10;
  localparam int SPM_SER_WRITE_BIT = 7;
  typedef enum {HOP_OFF, HOP_WAIT_HEADER, HOP_RUN} spm_hop_state_t;
endpackage

/* src/spm_serial_port.sv */
`timescale 1ns/10ps
// Host serial port: byte 0 = write flag + 7-bit address, byte 1 = data.
// Clock idles low; data sampled on rising, shifted out on falling edge.
module spm_serial_port
  import spm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Serial pins
  input wire logic ser_clk,
  input wire logic ser_select_n,
  input wire logic ser_data_in,
  output logic ser_data_out,
  // Register access
  output logic [6:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data
);
  // ==========================================
  // Pin synchronisers
  logic [2:0] sync_clk, sync_sel, sync_din;
  logic clk_q, sel_q, din_q;
  logic next_clk_q, next_sel_q, next_din_q;

  always_comb
  begin
    // A pin counts as changed only once the 2nd and 3rd stages agree
    next_clk_q = (sync_clk[1] == sync_clk[2]) ? sync_clk[2] : clk_q;
    next_sel_q = (sync_sel[1] == sync_sel[2]) ? sync_sel[2] : sel_q;
    next_din_q = (sync_din[1] == sync_din[2]) ? sync_din[2] : din_q;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      sync_clk <= 3'h0;
      sync_sel <= 3'h7;
      sync_din <= 3'h0;
      clk_q <= 1'b0;
      sel_q <= 1'b1;
      din_q <= 1'b0;
    end
    else
    begin
      sync_clk <= {sync_clk[1:0], ser_clk};
      sync_sel <= {sync_sel[1:0], ser_select_n};
      sync_din <= {sync_din[1:0], ser_data_in};
      clk_q <= next_clk_q;
      sel_q <= next_sel_q;
      din_q <= next_din_q;
    end
  end

  // ==========================================
  // Frame engine
  logic rise, fall;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift_in, next_shift_in;
  logic [7:0] shift_out, next_shift_out;
  logic write_flag, next_write_flag;
  logic [6:0] next_reg_addr;
  logic next_reg_wr;
  logic [7:0] next_reg_wr_data;

  assign rise = next_clk_q & ~clk_q;
  assign fall = ~next_clk_q & clk_q;
  assign ser_data_out = shift_out[7];

  always_comb
  begin
    next_bit_cnt = bit_cnt;
    next_shift_in = shift_in;
    next_shift_out = shift_out;
    next_write_flag = write_flag;
    next_reg_addr = reg_addr;
    next_reg_wr = 1'b0;
    next_reg_wr_data = reg_wr_data;
    if (sel_q)
    begin
      // Deselect aborts any partial frame; only whole frames write
      next_bit_cnt = 5'h00;
      next_shift_out = 8'h00;
    end
    else
    begin
      if (rise && bit_cnt < SPM_SER_FRAME_BITS)
      begin
        next_shift_in = {shift_in[6:0], din_q};
        next_bit_cnt = bit_cnt + 5'h01;
        if (bit_cnt + 5'h01 == SPM_SER_HEADER_BITS)
        begin
          next_write_flag = shift_in[SPM_SER_WRITE_BIT - 1];
          next_reg_addr = {shift_in[5:0], din_q};
        end
        if (bit_cnt + 5'h01 == SPM_SER_FRAME_BITS)
        begin
          next_reg_wr = write_flag;
          next_reg_wr_data = {shift_in[6:0], din_q};
        end
      end
      if (fall)
      begin
        // Read data is loaded a full half period after the address settles
        if (bit_cnt == SPM_SER_HEADER_BITS)
          next_shift_out = reg_rd_data;
        else
          next_shift_out = {shift_out[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      bit_cnt <= 5'h00;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      write_flag <= 1'b0;
      reg_addr <= 7'h00;
      reg_wr <= 1'b0;
      reg_wr_data <= 8'h00;
    end
    else
    begin
      bit_cnt <= next_bit_cnt;
      shift_in <= next_shift_in;
      shift_out <= next_shift_out;
      write_flag <= next_write_flag;
      reg_addr <= next_reg_addr;
      reg_wr <= next_reg_wr;
      reg_wr_data <= next_reg_wr_data;
    end
  end
endmodule
